// >>> rtl/rst_pwr_pkg.sv
// Constants for the reset and power-mode controller
package rst_pwr_pkg;
	// Register addresses (8-bit special-function space)
	localparam logic [7:0] ADDR_INT_SER_STATUS = 8'h00_C5;
	localparam logic [7:0] ADDR_SER_STATUS_EXT = 8'h00_F7;
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h00_87;
	localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'h00_D8;
	localparam logic [7:0] ADDR_EXT_INT_FLAGS = 8'h00_91;
	localparam logic [7:0] ADDR_CLOCK_DIVISOR = 8'h00_C4;
	localparam logic [7:0] ADDR_TIMED_ACCESS = 8'h00_C7;
	// Field positions
	localparam int BIT_PWRFAIL_IN_SVC = 7;
	localparam int BIT_HIGH_IN_SVC = 6;
	localparam int BIT_LOW_IN_SVC = 5;
	localparam int BIT_IDLE = 0;
	localparam int BIT_STOP = 1;
	localparam int BIT_OSC_FAIL_EN = 4;
	localparam int BIT_OSC_FAIL_FLAG = 5;
	localparam int BIT_POR_FLAG = 6;
	localparam int BIT_WARN_EN = 5;
	localparam int BIT_WARN_FLAG = 4;
	localparam int BIT_BANDGAP_KEEP = 0;
	localparam int DIV_LSB = 6;
	// Timed-access key bytes
	localparam logic [7:0] TA_KEY1 = 8'h00_AA;
	localparam logic [7:0] TA_KEY2 = 8'h00_55;
	localparam logic [1:0] TA_WINDOW_CYC = 2'h3;
	// Reset values
	localparam logic [1:0] DIV_RESET = 2'h2;
	// Timing
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_PER_MC = 4;
	localparam int LONG_RESET_CYC = 65_536;
	localparam int EXT_RESET_CYC = 4;
	localparam int WDT_RESET_CYC = 2 * CLK_PER_MC;
	localparam int CNT_W = 17;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_IDLE = 2'b01,
		ST_STOP = 2'b10
	} pmode_t;
endpackage : rst_pwr_pkg

// >>> rtl/sync_edge.sv
// Two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ps
module sync_edge (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic d_in,
	output logic level_out,
	output logic rise_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else if (ce_in) begin
			s1_q <= d_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign level_out = s2_q;
	assign rise_out = s2_q & ~s3_q;
endmodule : sync_edge

// >>> rtl/reset_timer.sv
// Down counter that stretches a reset pulse
`timescale 1ns/1ps
module reset_timer (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic load_in,
	input wire logic [16:0] count_in,
	input wire logic hold_in,
	output logic busy_out
);
	logic [16:0] cnt_q;
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_q <= 17'h0_0000;
		end else if (ce_in) begin
			if (load_in || hold_in) begin
				cnt_q <= count_in;
			end else if (cnt_q != 17'h0_0000) begin
				cnt_q <= cnt_q - 17'h0_0001;
			end
		end
	end
	assign busy_out = (cnt_q != 17'h0_0000);
endmodule : reset_timer

// >>> rtl/reset_power_ctrl.sv
// Reset sources, reset output timing and power-mode control
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
// How it works
// - Status bits 7,6,5 show power-fail, high and low level in service.
// - Divisor writes are ignored while any serial port is busy.
// - Per-port transmit and receive activity flags readable in two registers.
// - Enabled oscillator-fail detection holds the device in reset.
// - Detect enable bit 4 writable only inside a timed-access window.
// - Osc-fail sets flag bit 5; cleared by power-fail reset or writing zero.
// - Oscillator halt on stop entry never triggers the detector.
// - Reset held while a supply is low; full power-on reset on recovery.
// - After supplies recover, count 65,536 clocks before running from 0000h.
// - Power-on flag set on power-on reset; software clears it.
// - Enabled supply warning vectors to 0033h at highest priority.
// - Warning interrupt enabled only by control bit 5.
// - Warning sets flag bit 4 regardless of enable; software clears it.
// - Reset output low on external, watchdog, osc-fail, power-fail reset.
// - Output lasts 65,536 clocks long, one machine cycle external, two watchdog.
// - Idle bit halts execution; any interrupt or reset exits.
// - Stop bit stops internal clocking at the end of the instruction.
// - Stop entered only with CAN disabled and Ethernet asleep.
// - Stop exits only on external, Ethernet, CAN interrupt, reset or (bandgap kept) warning.
// - Bandgap keep bit holds reference on in stop; bandgap_enable_out is the bit in every mode.
// - With bandgap kept, power-fail reset and warning wake from stop.
module reset_power_ctrl (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic [2:0] level_in_service_in,
	input wire logic [2:0] ser_tx_busy_in,
	input wire logic [2:0] ser_rx_busy_in,
	input wire logic osc_slow_in,
	input wire logic supply_low_in,
	input wire logic supply_warn_in,
	input wire logic ext_reset_in,
	input wire logic watchdog_timeout_in,
	input wire logic instr_end_in,
	input wire logic any_irq_in,
	input wire logic ext_irq_in,
	input wire logic eth_pm_irq_in,
	input wire logic can_irq_in,
	input wire logic can_software_init_in,
	input wire logic can_controller_reset_in,
	input wire logic eth_sleep_in,
	output logic reset_output_low_out,
	output logic core_reset_out,
	output logic idle_out,
	output logic stop_out,
	output logic bandgap_enable_out,
	output logic [1:0] clock_divisor_out,
	output logic warn_irq_req_out,
	output logic [23:0] warn_vector_out
);
	localparam logic [23:0] WARN_VECTOR = 24'h00_0033;
	localparam logic [16:0] LONG_CNT = 17'(rst_pwr_pkg::LONG_RESET_CYC);
	// Load edge already drives the output low, so short counts load one less
	localparam logic [16:0] EXT_CNT = 17'(rst_pwr_pkg::EXT_RESET_CYC - 1);
	localparam logic [16:0] WDT_CNT = 17'(rst_pwr_pkg::WDT_RESET_CYC - 1);

	rst_pwr_pkg::pmode_t mode_q;
	logic osc_fail_en_q;
	logic osc_fail_flag_q;
	logic por_flag_q;
	logic warn_en_q;
	logic warn_flag_q;
	logic bandgap_keep_q;
	logic [1:0] div_q;
	logic [1:0] ta_cnt_q;
	logic ta_stage_q;
	logic stop_req_q;
	logic [7:0] rdata_q;
	logic rst_out_q;
	logic core_rst_q;
	logic irq_q;
	logic warn_level;
	logic warn_rise;
	logic low_level;
	logic low_rise;
	logic bandgap_on;
	logic osc_fail_evt;
	logic long_load;
	logic ext_load;
	logic wdt_load;
	logic timer_load;
	logic [16:0] timer_count;
	logic timer_busy;
	logic ser_busy;
	logic ta_open;
	logic stop_ok;
	logic stop_wake;
	logic [7:0] power_control_reg_view;
	logic [7:0] watchdog_control_reg_view;

	assign bandgap_on = (mode_q != rst_pwr_pkg::ST_STOP) | bandgap_keep_q;
	assign ser_busy = |(ser_tx_busy_in | ser_rx_busy_in);
	assign ta_open = (ta_cnt_q != 2'h0);

	// Comparator outputs are gated by the bandgap and synchronised
	sync_edge u_sync_low (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.ce_in(ce_in),
		.d_in(supply_low_in & bandgap_on),
		.level_out(low_level),
		.rise_out(low_rise)
	);
	sync_edge u_sync_warn (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.ce_in(ce_in),
		.d_in(supply_warn_in & bandgap_on),
		.level_out(warn_level),
		.rise_out(warn_rise)
	);

	// Detector is blind in stop mode since the oscillator is halted on purpose
	assign osc_fail_evt = osc_fail_en_q & osc_slow_in &
		(mode_q != rst_pwr_pkg::ST_STOP);
	assign long_load = low_rise | osc_fail_evt;
	assign ext_load = ext_reset_in;
	assign wdt_load = watchdog_timeout_in;
	assign timer_load = long_load | ext_load | wdt_load;
	always_comb begin
		if (long_load || low_level) begin
			timer_count = LONG_CNT;
		end else if (wdt_load) begin
			timer_count = WDT_CNT;
		end else begin
			timer_count = EXT_CNT;
		end
	end

	// Long sources hold the counter reloaded while their condition stays
	reset_timer u_timer (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.ce_in(ce_in),
		.load_in(timer_load),
		.count_in(timer_count),
		.hold_in(low_level | osc_fail_evt | ext_reset_in),
		.busy_out(timer_busy)
	);

	// Reset outputs change on the clock edge, and at once when nrst_in falls
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_out_q <= 1'b0;
			core_rst_q <= 1'b1;
		end else if (ce_in) begin
			rst_out_q <= ~(timer_busy | timer_load);
			core_rst_q <= timer_busy | timer_load;
		end
	end

	// Timed-access window: key1 then key2 opens a short window
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ta_stage_q <= 1'b0;
			ta_cnt_q <= 2'h0;
		end else if (ce_in) begin
			if (wr_in && addr_in == rst_pwr_pkg::ADDR_TIMED_ACCESS) begin
				ta_stage_q <= (wdata_in == rst_pwr_pkg::TA_KEY1);
				if (ta_stage_q && wdata_in == rst_pwr_pkg::TA_KEY2) begin
					ta_cnt_q <= rst_pwr_pkg::TA_WINDOW_CYC;
				end
			end else if (ta_open) begin
				ta_cnt_q <= ta_cnt_q - 2'h1;
			end
		end
	end

	// Power control: enable bit and oscillator-fail flag
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			osc_fail_en_q <= 1'b0;
			osc_fail_flag_q <= 1'b0;
		end else if (ce_in) begin
			if (wr_in && addr_in == rst_pwr_pkg::ADDR_POWER_CONTROL
					&& ta_open) begin
				osc_fail_en_q <= wdata_in[rst_pwr_pkg::BIT_OSC_FAIL_EN];
			end
			if (osc_fail_evt) begin
				osc_fail_flag_q <= 1'b1;
			end else if (low_rise) begin
				osc_fail_flag_q <= 1'b0;
			end else if (wr_in && addr_in == rst_pwr_pkg::ADDR_POWER_CONTROL
					&& !wdata_in[rst_pwr_pkg::BIT_OSC_FAIL_FLAG]) begin
				osc_fail_flag_q <= 1'b0;
			end
		end
	end

	// Watchdog control: power-on flag, warning enable and flag
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			por_flag_q <= 1'b1;
			warn_en_q <= 1'b0;
			warn_flag_q <= 1'b0;
		end else if (ce_in) begin
			if (wr_in && addr_in == rst_pwr_pkg::ADDR_WATCHDOG_CONTROL) begin
				warn_en_q <= wdata_in[rst_pwr_pkg::BIT_WARN_EN];
			end
			if (low_rise) begin
				por_flag_q <= 1'b1;
			end else if (wr_in && addr_in == rst_pwr_pkg::ADDR_WATCHDOG_CONTROL
					&& !wdata_in[rst_pwr_pkg::BIT_POR_FLAG]) begin
				por_flag_q <= 1'b0;
			end
			if (warn_rise) begin
				warn_flag_q <= 1'b1;
			end else if (wr_in && addr_in == rst_pwr_pkg::ADDR_WATCHDOG_CONTROL
					&& !wdata_in[rst_pwr_pkg::BIT_WARN_FLAG]) begin
				warn_flag_q <= 1'b0;
			end
		end
	end

	// Warning interrupt request, highest priority fixed vector
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_q <= 1'b0;
		end else if (ce_in) begin
			irq_q <= warn_en_q & warn_flag_q & ~core_rst_q;
		end
	end

	// Bandgap keep bit and clock divisor with serial lockout
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bandgap_keep_q <= 1'b0;
			div_q <= rst_pwr_pkg::DIV_RESET;
		end else if (ce_in) begin
			if (wr_in && addr_in == rst_pwr_pkg::ADDR_EXT_INT_FLAGS) begin
				bandgap_keep_q <= wdata_in[rst_pwr_pkg::BIT_BANDGAP_KEEP];
			end
			if (core_rst_q) begin
				div_q <= rst_pwr_pkg::DIV_RESET;
			end else if (wr_in && addr_in == rst_pwr_pkg::ADDR_CLOCK_DIVISOR
					&& !ser_busy) begin
				div_q <= wdata_in[rst_pwr_pkg::DIV_LSB +: 2];
			end
		end
	end

	// Power modes
	assign stop_ok = (can_software_init_in | can_controller_reset_in)
		& eth_sleep_in;
	assign stop_wake = ext_irq_in | eth_pm_irq_in | can_irq_in
		| (bandgap_keep_q & (low_level | warn_level));
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mode_q <= rst_pwr_pkg::ST_RUN;
			stop_req_q <= 1'b0;
		end else if (ce_in) begin
			if (core_rst_q) begin
				mode_q <= rst_pwr_pkg::ST_RUN;
				stop_req_q <= 1'b0;
			end else begin
				case (mode_q)
					rst_pwr_pkg::ST_RUN: begin
						if (wr_in && addr_in == rst_pwr_pkg::ADDR_POWER_CONTROL) begin
							stop_req_q <= wdata_in[rst_pwr_pkg::BIT_STOP] & stop_ok;
							if (wdata_in[rst_pwr_pkg::BIT_IDLE]) begin
								mode_q <= rst_pwr_pkg::ST_IDLE;
							end
						end else if (stop_req_q && instr_end_in) begin
							stop_req_q <= 1'b0;
							mode_q <= rst_pwr_pkg::ST_STOP;
						end
					end
					rst_pwr_pkg::ST_IDLE: begin
						if (any_irq_in) begin
							mode_q <= rst_pwr_pkg::ST_RUN;
						end
					end
					rst_pwr_pkg::ST_STOP: begin
						if (stop_wake) begin
							mode_q <= rst_pwr_pkg::ST_RUN;
						end
					end
					default: begin
						mode_q <= rst_pwr_pkg::ST_RUN;
					end
				endcase
			end
		end
	end

	// Register read mux, data one cycle after the strobe
	always_comb begin
		power_control_reg_view = 8'h00_00;
		power_control_reg_view[rst_pwr_pkg::BIT_OSC_FAIL_FLAG] = osc_fail_flag_q;
		power_control_reg_view[rst_pwr_pkg::BIT_OSC_FAIL_EN] = osc_fail_en_q;
		power_control_reg_view[rst_pwr_pkg::BIT_STOP] = (mode_q == rst_pwr_pkg::ST_STOP);
		power_control_reg_view[rst_pwr_pkg::BIT_IDLE] = (mode_q == rst_pwr_pkg::ST_IDLE);
		watchdog_control_reg_view = 8'h00_00;
		watchdog_control_reg_view[rst_pwr_pkg::BIT_POR_FLAG] = por_flag_q;
		watchdog_control_reg_view[rst_pwr_pkg::BIT_WARN_EN] = warn_en_q;
		watchdog_control_reg_view[rst_pwr_pkg::BIT_WARN_FLAG] = warn_flag_q;
	end
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_q <= 8'h00_00;
		end else if (ce_in) begin
			if (!rd_in) begin
				rdata_q <= 8'h00_00;
			end else if (addr_in == rst_pwr_pkg::ADDR_INT_SER_STATUS) begin
				rdata_q <= {level_in_service_in, ser_tx_busy_in[1:0],
					ser_rx_busy_in[1:0], 1'b0};
			end else if (addr_in == rst_pwr_pkg::ADDR_SER_STATUS_EXT) begin
				rdata_q <= {6'h00, ser_tx_busy_in[2], ser_rx_busy_in[2]};
			end else if (addr_in == rst_pwr_pkg::ADDR_POWER_CONTROL) begin
				rdata_q <= power_control_reg_view;
			end else if (addr_in == rst_pwr_pkg::ADDR_WATCHDOG_CONTROL) begin
				rdata_q <= watchdog_control_reg_view;
			end else if (addr_in == rst_pwr_pkg::ADDR_EXT_INT_FLAGS) begin
				rdata_q <= {7'h00, bandgap_keep_q};
			end else if (addr_in == rst_pwr_pkg::ADDR_CLOCK_DIVISOR) begin
				rdata_q <= {div_q, 6'h00};
			end else begin
				rdata_q <= 8'h00_00;
			end
		end
	end

	assign rdata_out = rdata_q;
	assign reset_output_low_out = rst_out_q;
	assign core_reset_out = core_rst_q;
	assign idle_out = mode_q[0];
	assign stop_out = mode_q[1];
	assign bandgap_enable_out = bandgap_keep_q;
	assign clock_divisor_out = div_q;
	assign warn_irq_req_out = irq_q;
	assign warn_vector_out = WARN_VECTOR;

	chk_osc_fail_sets: assert property (@(posedge clk_sys_in)
		disable iff (!nrst_in) ce_in && osc_fail_evt |=> osc_fail_flag_q
			&& !rst_out_q) else $error("osc fail not flagged");
	chk_osc_stop_blind: assert property (@(posedge clk_sys_in)
		disable iff (!nrst_in) ce_in && mode_q == rst_pwr_pkg::ST_STOP
			&& osc_slow_in && !core_rst_q && !ext_reset_in
			&& !watchdog_timeout_in && !low_rise |=> !core_rst_q)
		else $error("osc detector fired in stop");
	chk_div_lockout: assert property (@(posedge clk_sys_in)
		disable iff (!nrst_in) ce_in && ser_busy && !core_rst_q
			|=> $stable(div_q)) else $error("divisor changed while busy");
	chk_warn_flag_set: assert property (@(posedge clk_sys_in)
		disable iff (!nrst_in) ce_in && warn_rise |=> warn_flag_q)
		else $error("warning flag not set");
	chk_irq_needs_en: assert property (@(posedge clk_sys_in)
		disable iff (!nrst_in) irq_q |-> $past(warn_en_q))
		else $error("warning irq without enable");
	chk_long_reset: assert property (@(posedge clk_sys_in)
		disable iff (!nrst_in) ce_in && low_rise ##1 ce_in[*8]
			|-> !rst_out_q) else $error("long reset cut short");
	chk_rst_out_low: assert property (@(posedge clk_sys_in)
		disable iff (!nrst_in) ce_in && (ext_reset_in || watchdog_timeout_in)
			|=> !rst_out_q && core_rst_q) else $error("reset out missing");
	chk_stop_gate: assert property (@(posedge clk_sys_in)
		disable iff (!nrst_in) $rose(mode_q == rst_pwr_pkg::ST_STOP)
			|-> $past(stop_req_q)) else $error("stop without request");
endmodule : reset_power_ctrl

// >>> dv/reset_partner.sv
// External reset source and reset-output receiver model
`timescale 1ns/1ps
module reset_partner (
	input wire logic clk_sys_in,
	input wire logic reset_output_low_in,
	output logic ext_reset_out
);
	int cur_len;
	int low_len;
	initial begin
		ext_reset_out = 1'b0;
		cur_len = 0;
		low_len = 0;
	end
	// Receiver measures how long the reset output stayed low
	always @(posedge clk_sys_in) begin
		if (reset_output_low_in !== 1'b1) begin
			cur_len <= cur_len + 1;
		end else if (cur_len != 0) begin
			low_len <= cur_len;
			cur_len <= 0;
		end
	end
	// High pulse on the external reset line
	task automatic pulse(input int n);
		@(posedge clk_sys_in);
		ext_reset_out <= 1'b1;
		repeat (n) @(posedge clk_sys_in);
		ext_reset_out <= 1'b0;
	endtask : pulse
endmodule : reset_partner

// >>> dv/testbench.sv
// Register, reset and power-mode scenarios for the controller
`timescale 1ns/1ps
module testbench;
	logic clk_sys_in, nrst_in, wr_in, rd_in, osc_slow_in, supply_low_in;
	logic supply_warn_in, ext_reset_in, watchdog_timeout_in, instr_end_in;
	logic any_irq_in, ext_irq_in, can_software_init_in, eth_sleep_in;
	logic eth_pm_irq_in, can_irq_in, can_controller_reset_in;
	logic [7:0] addr_in, wdata_in, rdata_out;
	logic [2:0] lis_in, tx_in, rx_in;
	logic reset_output_low_out, core_reset_out, idle_out, stop_out;
	logic bandgap_enable_out, warn_irq_req_out;
	logic [1:0] clock_divisor_out;
	logic [23:0] warn_vector_out;
	int failures, checked;
	logic [7:0] rd_v;
	reset_power_ctrl dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
		.ce_in(1'b1), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .level_in_service_in(lis_in),
		.ser_tx_busy_in(tx_in), .ser_rx_busy_in(rx_in),
		.osc_slow_in(osc_slow_in), .supply_low_in(supply_low_in),
		.supply_warn_in(supply_warn_in), .ext_reset_in(ext_reset_in),
		.watchdog_timeout_in(watchdog_timeout_in), .instr_end_in(instr_end_in),
		.any_irq_in(any_irq_in), .ext_irq_in(ext_irq_in),
		.eth_pm_irq_in(eth_pm_irq_in), .can_irq_in(can_irq_in),
		.can_software_init_in(can_software_init_in),
		.can_controller_reset_in(can_controller_reset_in),
		.eth_sleep_in(eth_sleep_in),
		.reset_output_low_out(reset_output_low_out),
		.core_reset_out(core_reset_out), .idle_out(idle_out),
		.stop_out(stop_out), .bandgap_enable_out(bandgap_enable_out),
		.clock_divisor_out(clock_divisor_out),
		.warn_irq_req_out(warn_irq_req_out), .warn_vector_out(warn_vector_out));
	reset_partner partner_u (.clk_sys_in(clk_sys_in),
		.reset_output_low_in(reset_output_low_out),
		.ext_reset_out(ext_reset_in));
	initial begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
	endtask : wr
	task automatic bus_idle();
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		rd_in <= 1'b0;
	endtask : bus_idle
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 rd_v = rdata_out;
	endtask : rd
	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask : cycles
	function automatic logic sig(input int s);
		case (s)
			0: return core_reset_out;
			1: return reset_output_low_out;
			2: return stop_out;
			default: return idle_out;
		endcase
	endfunction : sig
	task automatic wait_on(input int s, input logic v, input int lim);
		int n;
		n = 0;
		while (sig(s) !== v && n < lim) begin
			cycles(1);
			n++;
		end
		if (n >= lim) begin
			failures++;
			$display("ERROR %0t: wait for signal %0d ran out", $time, s);
			wrap_up();
		end
	endtask : wait_on
	task automatic enter_stop();
		wr(8'h87, 8'h02);
		bus_idle();
		@(posedge clk_sys_in);
		instr_end_in <= 1'b1;
		@(posedge clk_sys_in);
		instr_end_in <= 1'b0;
		cycles(3);
	endtask : enter_stop
	task automatic timed_access();
		wr(8'hc7, 8'haa);
		wr(8'hc7, 8'h55);
	endtask : timed_access
	initial begin
		{nrst_in, wr_in, rd_in, osc_slow_in, supply_low_in} = '0;
		{supply_warn_in, watchdog_timeout_in, instr_end_in} = '0;
		{any_irq_in, ext_irq_in, can_software_init_in, eth_sleep_in} = '0;
		{eth_pm_irq_in, can_irq_in, can_controller_reset_in} = '0;
		{addr_in, wdata_in, lis_in, tx_in, rx_in} = '0;
		failures = 0;
		checked = 0;
		cycles(10);
		nrst_in <= 1'b1;
		cycles(2);
		rd(8'hc4); check(rd_v, 24'h00_0080);
		rd(8'h91); check(rd_v, 24'h00_0000);
		rd(8'hd8); check(rd_v, 24'h00_0040);
		rd(8'h00); check(rd_v, 24'h00_0000);
		check(warn_vector_out, 24'h00_0033);
		// Status registers
		lis_in <= 3'b101; tx_in <= 3'b110; rx_in <= 3'b011;
		rd(8'hc5); check(rd_v, 24'h00_00b6);
		rd(8'hf7); check(rd_v, 24'h00_0002);
		lis_in <= 3'b010; tx_in <= 3'b001; rx_in <= 3'b100;
		rd(8'hc5); check(rd_v, 24'h00_0048);
		rd(8'hf7); check(rd_v, 24'h00_0001);
		// Divisor lockout while a port is busy
		wr(8'hc4, 8'hc0); bus_idle(); cycles(2);
		check(clock_divisor_out, 24'h00_0002);
		tx_in <= 3'b000; rx_in <= 3'b000; cycles(2);
		rd(8'hc5); check(rd_v, 24'h00_0040);
		wr(8'hc4, 8'hc0); bus_idle(); cycles(2);
		check(clock_divisor_out, 24'h00_0003);
		wr(8'hc4, 8'h80); bus_idle();
		// Power-on flag and supply warning
		wr(8'hd8, 8'h00); bus_idle();
		rd(8'hd8); check(rd_v, 24'h00_0000);
		supply_warn_in <= 1'b1; cycles(5); supply_warn_in <= 1'b0;
		rd(8'hd8); check(rd_v, 24'h00_0010);
		check(warn_irq_req_out, 24'h00_0000);
		wr(8'hd8, 8'h30); bus_idle(); cycles(2);
		check(warn_irq_req_out, 24'h00_0001);
		wr(8'hd8, 8'h20); bus_idle(); cycles(2);
		rd(8'hd8); check(rd_v, 24'h00_0020);
		check(warn_irq_req_out, 24'h00_0000);
		wr(8'hd8, 8'h00); bus_idle();
		// Oscillator-fail enable needs the timed sequence
		wr(8'h87, 8'h10); bus_idle();
		rd(8'h87); check(rd_v, 24'h00_0000);
		timed_access(); wr(8'h87, 8'h10); bus_idle();
		rd(8'h87); check(rd_v, 24'h00_0010);
		// Idle and stop modes
		wr(8'h87, 8'h01); bus_idle(); cycles(2);
		check(idle_out, 24'h00_0001);
		any_irq_in <= 1'b1; wait_on(3, 1'b0, 10); any_irq_in <= 1'b0;
		enter_stop(); check(stop_out, 24'h00_0000);
		can_software_init_in <= 1'b1; eth_sleep_in <= 1'b1;
		wr(8'h91, 8'h01); bus_idle(); cycles(2);
		enter_stop(); check(stop_out, 24'h00_0001);
		check(bandgap_enable_out, 24'h00_0001);
		osc_slow_in <= 1'b1; any_irq_in <= 1'b1; cycles(20);
		check(stop_out, 24'h00_0001);
		check(core_reset_out, 24'h00_0000);
		osc_slow_in <= 1'b0; any_irq_in <= 1'b0; cycles(3);
		ext_irq_in <= 1'b1; wait_on(2, 1'b0, 20); ext_irq_in <= 1'b0;
		enter_stop(); check(stop_out, 24'h00_0001);
		supply_warn_in <= 1'b1; wait_on(2, 1'b0, 20);
		supply_warn_in <= 1'b0;
		wr(8'hd8, 8'h00); bus_idle(); cycles(2);
		can_software_init_in <= 1'b0; can_controller_reset_in <= 1'b1;
		enter_stop(); check(stop_out, 24'h00_0001);
		can_irq_in <= 1'b1; wait_on(2, 1'b0, 20); can_irq_in <= 1'b0;
		enter_stop(); check(stop_out, 24'h00_0001);
		eth_pm_irq_in <= 1'b1; wait_on(2, 1'b0, 20);
		eth_pm_irq_in <= 1'b0; cycles(2);
		// Reset output lengths per source
		partner_u.pulse(1); cycles(1); wait_on(1, 1'b1, 20); cycles(2);
		check(24'(partner_u.low_len), 24'h00_0004);
		@(posedge clk_sys_in); watchdog_timeout_in <= 1'b1;
		@(posedge clk_sys_in); watchdog_timeout_in <= 1'b0;
		cycles(1); wait_on(1, 1'b1, 20); cycles(2);
		check(24'(partner_u.low_len), 24'h00_0008);
		timed_access(); wr(8'h87, 8'h10); bus_idle();
		osc_slow_in <= 1'b1; wait_on(0, 1'b1, 20);
		check(reset_output_low_out, 24'h00_0000);
		cycles(3); osc_slow_in <= 1'b0;
		wait_on(1, 1'b1, 70000); cycles(3);
		check(partner_u.low_len >= 65536, 1);
		check(partner_u.low_len <= 65545, 1);
		rd(8'h87); check(rd_v & 8'h20, 24'h00_0020);
		wr(8'h87, 8'h00); bus_idle();
		rd(8'h87); check(rd_v & 8'h20, 24'h00_0000);
		// Supply below threshold
		supply_low_in <= 1'b1; wait_on(0, 1'b1, 10);
		cycles(50); check(reset_output_low_out, 24'h00_0000);
		supply_low_in <= 1'b0; cycles(1000);
		check(core_reset_out, 24'h00_0001);
		rd(8'hd8); check(rd_v, 24'h00_0040);
		nrst_in <= 1'b0; cycles(10); nrst_in <= 1'b1; cycles(2);
		rd(8'hd8); check(rd_v, 24'h00_0040);
		wrap_up();
	end
endmodule : testbench
